// ---- rtl/ccs_params.svh ----
// Constants of the capture/compare status, shutdown and dead-time block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CCS_ADDR_W        4
`define CCS_OFF_CON3      4'h0
`define CCS_OFF_STAT      4'h4
`define CCS_OFF_IRQ_MASK  4'h8
`define CCS_OFF_IRQ_STAT  4'hc

// ----------------------------------------------------------------------------
// Control three fields
// ----------------------------------------------------------------------------
`define CCS_CON3_HOLD     31
`define CCS_CON3_TRIGGERED_OPERATION_ENABLE   30
`define CCS_CON3_SDA_HI   19
`define CCS_CON3_SDA_LO   18
`define CCS_CON3_SDB_HI   17
`define CCS_CON3_SDB_LO   16
`define CCS_CON3_DT_HI    5
`define CCS_CON3_DT_LO    0
`define CCS_CON3_RST      32'h0000_0000

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define CCS_ST_PRL        20
`define CCS_ST_TMRH       19
`define CCS_ST_TMRL       18
`define CCS_ST_RB         17
`define CCS_ST_RA         16
`define CCS_ST_GARM       10
`define CCS_ST_TRIG       7
`define CCS_ST_TSET       6
`define CCS_ST_TCLR       5
`define CCS_ST_ASD        4
`define CCS_ST_SCE        3
`define CCS_ST_CDIS       2
`define CCS_ST_OVF        1
`define CCS_ST_BNE        0

// ----------------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------------
`define CCS_IRQ_W         4
`define CCS_IRQ_ASD       0
`define CCS_IRQ_SCE       1
`define CCS_IRQ_OVF       2
`define CCS_IRQ_TRIG      3

`endif

// ---- rtl/ccs_pkg.sv ----
// Types of the capture/compare status, shutdown and dead-time block
package ccs_pkg;
  // Pin group drive state
  typedef enum logic [1:0] {
    CCS_DRV_HIZ      = 2'b00,
    CCS_DRV_INACTIVE = 2'b10,
    CCS_DRV_ACTIVE   = 2'b11
  } ccs_drv_t;

  // Dead-time sequencer
  typedef enum logic [1:0] {
    CCS_DT_IDLE = 2'b00,
    CCS_DT_WAIT = 2'b01,
    CCS_DT_ON   = 2'b10
  } ccs_dt_state_t;
endpackage

// ---- rtl/ccs_status_shutdown.sv ----
// Status, auto-shutdown and dead-time logic of a capture/compare/PWM module
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "ccs_params.svh"

module ccs_status_shutdown #(
  parameter bit MULTI_OUTPUT = 1'b1
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`CCS_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Datapath status in
  input  wire logic                   period_busy,
  input  wire logic                   timer_high_busy,
  input  wire logic                   timer_low_busy,
  input  wire logic                   compare_b_busy,
  input  wire logic                   compare_a_busy,
  input  wire logic                   hw_trigger,
  input  wire logic                   single_edge_event,
  input  wire logic                   fifo_overflow,
  input  wire logic                   fifo_not_empty,
  input  wire logic [1:0]             capture_gate_mode,
  input  wire logic                   pwm_raw,
  // Pins
  input  wire logic                   shutdown_pin,
  input  wire logic                   capture_pin,
  output logic      [2:0]             group_a_out,
  output logic      [2:0]             group_a_oe,
  output logic      [2:0]             group_b_out,
  output logic      [2:0]             group_b_oe,
  // Events to datapath
  output logic                        capture_event,
  output logic                        gate_arm_pulse,
  output logic                        gate_armed,
  output logic                        trigger_status,
  // Interrupt
  output logic                        irq
);
  import ccs_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [31:0]              con3_ff;
  logic                     trig_ff;
  logic                     asd_ff;
  logic                     sce_ff;
  logic                     cdis_ff;
  logic                     ovf_ff;
  logic                     armed_ff;
  logic [`CCS_IRQ_W-1:0]    irq_mask_ff;
  logic [`CCS_IRQ_W-1:0]    irq_stat_ff;
  logic [1:0]               sd_sync_ff;
  logic [1:0]               cap_sync_ff;
  logic                     cap_prev_ff;
  logic [5:0]               dt_cnt_ff;
  logic [5:0]               nxt_dt_cnt;
  ccs_dt_state_t            dt_state_ff;
  ccs_dt_state_t            nxt_dt_state;
  logic                     pwm_prev_ff;
  logic                     dt_gate_ff;
  logic [2:0]               a_out_ff;
  logic [2:0]               a_oe_ff;
  logic [2:0]               b_out_ff;
  logic [2:0]               b_oe_ff;
  logic                     wr_con3;
  logic                     wr_stat;
  logic                     rd_stat;
  logic                     rd_irq;
  logic                     trig_en;
  logic                     set_req;
  logic                     clr_req;
  logic                     arm_req;
  logic                     sd_event;
  logic                     trig_rise;
  logic [5:0]               dt_val;
  logic [1:0]               sdb_field;
  logic [`CCS_IRQ_W-1:0]    irq_events;
  logic [31:0]              con3_view;
  logic [31:0]              stat_view;
  logic [1:0]               drv_a;
  logic [1:0]               drv_b;
  logic                     out_hold;

  // Drive a three-pin group from a shutdown field or the live signal
  function automatic logic [1:0] drive_pin(input logic [1:0] field, input logic sd, input logic lvl);
    if (!sd)
      return {lvl, 1'b1};
    unique case (field)
      CCS_DRV_ACTIVE:   return 2'b11;
      CCS_DRV_INACTIVE: return 2'b01;
      default:          return 2'b00;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  assign wr_con3 = reg_wr && (reg_addr == `CCS_OFF_CON3);
  assign wr_stat = reg_wr && (reg_addr == `CCS_OFF_STAT);
  assign rd_stat = reg_rd && (reg_addr == `CCS_OFF_STAT);
  assign rd_irq  = reg_rd && (reg_addr == `CCS_OFF_IRQ_STAT);
  assign trig_en = con3_ff[`CCS_CON3_TRIGGERED_OPERATION_ENABLE];

  assign set_req = wr_stat && reg_wdata[`CCS_ST_TSET];
  assign clr_req = wr_stat && reg_wdata[`CCS_ST_TCLR];
  assign arm_req = wr_stat && reg_wdata[`CCS_ST_GARM];

  assign dt_val    = MULTI_OUTPUT ? con3_ff[`CCS_CON3_DT_HI:`CCS_CON3_DT_LO] : 6'h00;
  assign sdb_field = MULTI_OUTPUT ? con3_ff[`CCS_CON3_SDB_HI:`CCS_CON3_SDB_LO] : 2'h0;

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // Implemented control bits only
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      con3_ff <= `CCS_CON3_RST;
    else if (wr_con3) begin
      con3_ff <= 32'h0000_0000;
      con3_ff[`CCS_CON3_HOLD]   <= reg_wdata[`CCS_CON3_HOLD];
      con3_ff[`CCS_CON3_TRIGGERED_OPERATION_ENABLE] <= reg_wdata[`CCS_CON3_TRIGGERED_OPERATION_ENABLE];
      con3_ff[`CCS_CON3_SDA_HI:`CCS_CON3_SDA_LO] <= reg_wdata[`CCS_CON3_SDA_HI:`CCS_CON3_SDA_LO];
      con3_ff[`CCS_CON3_SDB_HI:`CCS_CON3_SDB_LO] <= reg_wdata[`CCS_CON3_SDB_HI:`CCS_CON3_SDB_LO];
      con3_ff[`CCS_CON3_DT_HI:`CCS_CON3_DT_LO]   <= reg_wdata[`CCS_CON3_DT_HI:`CCS_CON3_DT_LO];
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sd_sync_ff  <= 2'h0;
      cap_sync_ff <= 2'h0;
      cap_prev_ff <= 1'b0;
    end else begin
      sd_sync_ff  <= {sd_sync_ff[0], shutdown_pin};
      cap_sync_ff <= {cap_sync_ff[0], capture_pin};
      cap_prev_ff <= cap_sync_ff[1];
    end
  end

  assign sd_event = sd_sync_ff[1];

  assign capture_event = !cdis_ff && (cap_sync_ff[1] && !cap_prev_ff);

  // --------------------------------------------------------------------------
  // Trigger status
  // --------------------------------------------------------------------------
  // Set by hardware or request, cleared by request
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      trig_ff <= 1'b0;
    else if ((trig_en && set_req) || hw_trigger)
      trig_ff <= 1'b1;
    else if (trig_en && clr_req)
      trig_ff <= 1'b0;
  end

  assign trigger_status = trig_ff;
  assign trig_rise      = (trig_en && set_req && !trig_ff) || (hw_trigger && !trig_ff);

  // --------------------------------------------------------------------------
  // Sticky status flags and capture disable
  // --------------------------------------------------------------------------
  // Shutdown holds until cleared, event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      asd_ff <= 1'b0;
    else if (sd_event)
      asd_ff <= 1'b1;
    else if (wr_stat && !reg_wdata[`CCS_ST_ASD])
      asd_ff <= 1'b0;
  end

  // Compare flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      sce_ff <= 1'b0;
    else if (single_edge_event)
      sce_ff <= 1'b1;
    else if (wr_stat && !reg_wdata[`CCS_ST_SCE])
      sce_ff <= 1'b0;
  end

  // Overflow flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ovf_ff <= 1'b0;
    else if (fifo_overflow)
      ovf_ff <= 1'b1;
    else if (wr_stat && !reg_wdata[`CCS_ST_OVF])
      ovf_ff <= 1'b0;
  end

  // Capture disable, plain read/write bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cdis_ff <= 1'b0;
    else if (wr_stat)
      cdis_ff <= reg_wdata[`CCS_ST_CDIS];
  end

  // --------------------------------------------------------------------------
  // Gate arm
  // --------------------------------------------------------------------------
  // Arm one shot in gate modes 01 and 10
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      armed_ff <= 1'b0;
    else if (gate_arm_pulse)
      armed_ff <= 1'b1;
    else if (capture_event)
      armed_ff <= 1'b0;
  end

  assign gate_arm_pulse = arm_req && (capture_gate_mode == 2'b01 || capture_gate_mode == 2'b10);
  assign gate_armed     = armed_ff;

  // --------------------------------------------------------------------------
  // Dead-time sequencer
  // --------------------------------------------------------------------------
  // Delay each rising edge by dt_val cycles
  always_comb begin
    nxt_dt_state = dt_state_ff;
    nxt_dt_cnt   = dt_cnt_ff;
    unique case (dt_state_ff)
      CCS_DT_IDLE: begin
        if (pwm_raw && !pwm_prev_ff || pwm_raw && dt_val == 6'h00) begin
          nxt_dt_state = (dt_val == 6'h00) ? CCS_DT_ON : CCS_DT_WAIT;
          nxt_dt_cnt   = dt_val;
        end
      end
      CCS_DT_WAIT: begin
        if (!pwm_raw)
          nxt_dt_state = CCS_DT_IDLE;
        else if (dt_cnt_ff <= 6'h01)
          nxt_dt_state = CCS_DT_ON;
        else
          nxt_dt_cnt = dt_cnt_ff - 6'h01;
      end
      CCS_DT_ON: begin
        if (!pwm_raw)
          nxt_dt_state = CCS_DT_IDLE;
      end
      default: nxt_dt_state = CCS_DT_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dt_state_ff <= CCS_DT_IDLE;
      dt_cnt_ff   <= 6'h00;
      pwm_prev_ff <= 1'b0;
      dt_gate_ff  <= 1'b0;
    end else begin
      dt_state_ff <= nxt_dt_state;
      dt_cnt_ff   <= nxt_dt_cnt;
      pwm_prev_ff <= pwm_raw;
      dt_gate_ff  <= (nxt_dt_state == CCS_DT_ON);
    end
  end

  // --------------------------------------------------------------------------
  // Output pins
  // --------------------------------------------------------------------------
  // Shutdown state per group; hold until triggered
  assign out_hold = trig_en && con3_ff[`CCS_CON3_HOLD] && !trig_ff;
  assign drv_a    = drive_pin(con3_ff[`CCS_CON3_SDA_HI:`CCS_CON3_SDA_LO], asd_ff, dt_gate_ff);
  assign drv_b    = drive_pin(sdb_field, asd_ff, (dt_val == 6'h00) ? !pwm_raw : (!pwm_raw && dt_state_ff == CCS_DT_IDLE
                    && !pwm_prev_ff));

  // Registered pin drives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_out_ff <= 3'h0;
      a_oe_ff  <= 3'h0;
      b_out_ff <= 3'h0;
      b_oe_ff  <= 3'h0;
    end else begin
      a_out_ff <= {3{drv_a[1]}};
      a_oe_ff  <= {3{drv_a[0] && !out_hold}};
      b_out_ff <= {3{drv_b[1] && MULTI_OUTPUT}};
      b_oe_ff  <= {3{drv_b[0] && !out_hold && MULTI_OUTPUT}};
    end
  end

  assign group_a_out = a_out_ff;
  assign group_a_oe  = a_oe_ff;
  assign group_b_out = b_out_ff;
  assign group_b_oe  = b_oe_ff;

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign irq_events = {trig_rise, fifo_overflow, single_edge_event, sd_event};

  // Sticky events, cleared by read, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= irq_events | (rd_irq ? '0 : irq_stat_ff);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq_mask_ff <= '0;
    else if (reg_wr && reg_addr == `CCS_OFF_IRQ_MASK)
      irq_mask_ff <= reg_wdata[`CCS_IRQ_W-1:0];
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // --------------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------------
  // Unimplemented bits read zero
  always_comb begin
    con3_view = con3_ff;
    if (!MULTI_OUTPUT) begin
      con3_view[`CCS_CON3_SDB_HI:`CCS_CON3_SDB_LO] = 2'h0;
      con3_view[`CCS_CON3_DT_HI:`CCS_CON3_DT_LO]   = 6'h00;
    end
  end

  always_comb begin
    stat_view = 32'h0000_0000;
    stat_view[`CCS_ST_PRL]  = period_busy;
    stat_view[`CCS_ST_TMRH] = timer_high_busy;
    stat_view[`CCS_ST_TMRL] = timer_low_busy;
    stat_view[`CCS_ST_RB]   = compare_b_busy;
    stat_view[`CCS_ST_RA]   = compare_a_busy;
    stat_view[`CCS_ST_TRIG] = trig_ff;
    stat_view[`CCS_ST_ASD]  = asd_ff;
    stat_view[`CCS_ST_SCE]  = sce_ff;
    stat_view[`CCS_ST_CDIS] = cdis_ff;
    stat_view[`CCS_ST_OVF]  = ovf_ff;
    stat_view[`CCS_ST_BNE]  = fifo_not_empty;
  end

  // Read data one cycle after strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      unique case (reg_addr)
        `CCS_OFF_CON3:     reg_rdata <= con3_view;
        `CCS_OFF_STAT:     reg_rdata <= stat_view;
        `CCS_OFF_IRQ_MASK: reg_rdata <= {28'h0, irq_mask_ff};
        `CCS_OFF_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_ff};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end else
      reg_rdata <= 32'h0000_0000;
  end
endmodule

// ---- testbench/ccs_checker.sv ----
// Concurrent checks on the status, shutdown and dead-time block
`include "ccs_params.svh"
module ccs_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Register port
  input wire logic [`CCS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // Datapath status
  input wire logic                   period_busy,
  input wire logic                   timer_high_busy,
  input wire logic                   timer_low_busy,
  input wire logic                   compare_b_busy,
  input wire logic                   compare_a_busy,
  input wire logic                   hw_trigger,
  input wire logic                   fifo_not_empty,
  input wire logic [1:0]             capture_gate_mode,
  // Pins and events
  input wire logic                   shutdown_pin,
  input wire logic                   capture_pin,
  input wire logic [2:0]             group_a_out,
  input wire logic [2:0]             group_a_oe,
  input wire logic [2:0]             group_b_out,
  input wire logic [2:0]             group_b_oe,
  input wire logic                   capture_event,
  input wire logic                   gate_arm_pulse,
  input wire logic                   gate_armed,
  input wire logic                   trigger_status
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Decoded status reads and writes
  wire st_rd   = reg_rd && reg_addr == `CCS_OFF_STAT;
  wire st_wr   = reg_wr && reg_addr == `CCS_OFF_STAT;
  wire tset_wr = st_wr && reg_wdata[`CCS_ST_TSET];
  wire tclr_wr = st_wr && reg_wdata[`CCS_ST_TCLR];
  wire arm_wr  = st_wr && reg_wdata[`CCS_ST_GARM] && capture_gate_mode inside {2'b01, 2'b10};

  // Shutdown pin seen long enough to force the pins
  sequence sd_asserted;
    shutdown_pin [*6];
  endsequence

  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data not zero when idle");
  a_status_zero:
    assert property (st_rd |=> reg_rdata[31:21] == 11'h0 && reg_rdata[15:8] == 8'h0 && reg_rdata[6:5] == 2'h0)
    else $error("unimplemented status bits set");
  a_status_live:
    assert property (st_rd |=> reg_rdata[20:16] == {$past(period_busy), $past(timer_high_busy),
      $past(timer_low_busy), $past(compare_b_busy), $past(compare_a_busy)} && reg_rdata[0] == $past(fifo_not_empty))
    else $error("live status bits wrong");
  a_control_gap:
    assert property (reg_rd && reg_addr == `CCS_OFF_CON3 |=> reg_rdata[15:6] == 10'h0)
    else $error("control gap bits set");
  a_trig_cause:
    assert property ($rose(trigger_status) |-> $past(hw_trigger) || $past(tset_wr))
    else $error("trigger rose without cause");
  a_trig_cancel:
    assert property ($fell(trigger_status) |-> $past(tclr_wr)) else $error("trigger fell without clear");
  a_arm_pulse:
    assert property (gate_arm_pulse == arm_wr) else $error("gate arm pulse wrong");
  a_arm_holds:
    assert property (gate_arm_pulse && !capture_event |=> gate_armed) else $error("gate not armed");
  a_cap_cause:
    assert property (capture_event |-> ($past(capture_pin) || $past(capture_pin, 2) || $past(capture_pin, 3))
      ##1 !capture_event) else $error("capture event without pin edge");
  a_sd_frozen:
    assert property (sd_asserted |=> $stable(group_a_oe) && $stable(group_a_out) && $stable(group_b_oe)
      && $stable(group_b_out)) else $error("pins moved during shutdown");
endmodule

bind ccs_status_shutdown ccs_checker u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_busy(period_busy),
  .timer_high_busy(timer_high_busy), .timer_low_busy(timer_low_busy), .compare_b_busy(compare_b_busy),
  .compare_a_busy(compare_a_busy), .hw_trigger(hw_trigger), .fifo_not_empty(fifo_not_empty),
  .capture_gate_mode(capture_gate_mode), .shutdown_pin(shutdown_pin), .capture_pin(capture_pin),
  .group_a_out(group_a_out), .group_a_oe(group_a_oe), .group_b_out(group_b_out), .group_b_oe(group_b_oe),
  .capture_event(capture_event), .gate_arm_pulse(gate_arm_pulse), .gate_armed(gate_armed),
  .trigger_status(trigger_status));

// ---- testbench/ccs_pin_model.sv ----
// Far-side model: shutdown source, capture source and group A pads
module ccs_pin_model (
  // Commands from the bench
  input wire logic       sd_cmd,
  input wire logic       cap_cmd,
  // Device pins
  input wire logic [2:0] group_a_out,
  input wire logic [2:0] group_a_oe,
  output logic           shutdown_pin,
  output logic           capture_pin,
  output logic [2:0]     pad_a
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pad_a = 3'h0;
  // Foreign sources move off the clock edge
  assign #3 shutdown_pin = sd_cmd;
  assign #3 capture_pin  = cap_cmd;
  // Released pads drift to the inverse of their last level
  for (genvar i = 0; i < 3; i++) begin : g_pad
    always @(group_a_oe[i], group_a_out[i]) pad_a[i] = group_a_oe[i] ? group_a_out[i] : ~pad_a[i];
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the status, shutdown and dead-time block
`include "ccs_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [4:0] busy; logic ne; logic [31:0] exp;} ccs_row_t;
  // ------
  // Signals
  // ------
  logic        clk, rst, reg_wr, reg_rd, hw_trigger, single_edge_event, fifo_overflow, fifo_not_empty, pwm_raw;
  logic        sd_cmd, cap_cmd, shutdown_pin, capture_pin, capture_event, gate_arm_pulse, gate_armed;
  logic        trigger_status, irq;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  bsy;
  logic [1:0]  capture_gate_mode;
  logic [2:0]  group_a_out, group_a_oe, group_b_out, group_b_oe, pad_a, single_b_oe, single_b_out;
  int          error_cnt = 0, cmp_count = 0, cap_cnt = 0, n, d0, dn;
  logic [5:0]  dts [2] = '{6'h01, 6'h3f};
  logic [31:0] sd_con [2] = '{32'h000e_0000, 32'h0001_0000};
  ccs_row_t    rows [6] = '{'{5'h10, 1'b0, 32'h0010_0000}, '{5'h08, 1'b0, 32'h0008_0000},
    '{5'h04, 1'b0, 32'h0004_0000}, '{5'h02, 1'b0, 32'h0002_0000}, '{5'h01, 1'b0, 32'h0001_0000},
    '{5'h00, 1'b1, 32'h0000_0001}};
  // ------
  // Devices
  // ------
  ccs_status_shutdown #(.MULTI_OUTPUT(1'b1)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_busy(bsy[4]),
    .timer_high_busy(bsy[3]), .timer_low_busy(bsy[2]), .compare_b_busy(bsy[1]), .compare_a_busy(bsy[0]),
    .hw_trigger(hw_trigger), .single_edge_event(single_edge_event), .fifo_overflow(fifo_overflow),
    .fifo_not_empty(fifo_not_empty), .capture_gate_mode(capture_gate_mode), .pwm_raw(pwm_raw),
    .shutdown_pin(shutdown_pin), .capture_pin(capture_pin), .group_a_out(group_a_out), .group_a_oe(group_a_oe),
    .group_b_out(group_b_out), .group_b_oe(group_b_oe), .capture_event(capture_event),
    .gate_arm_pulse(gate_arm_pulse), .gate_armed(gate_armed), .trigger_status(trigger_status), .irq(irq));
  ccs_status_shutdown #(.MULTI_OUTPUT(1'b0)) DUT_single (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .period_busy(bsy[4]),
    .timer_high_busy(bsy[3]), .timer_low_busy(bsy[2]), .compare_b_busy(bsy[1]), .compare_a_busy(bsy[0]),
    .hw_trigger(hw_trigger), .single_edge_event(single_edge_event), .fifo_overflow(fifo_overflow),
    .fifo_not_empty(fifo_not_empty), .capture_gate_mode(capture_gate_mode), .pwm_raw(pwm_raw),
    .shutdown_pin(shutdown_pin), .capture_pin(capture_pin), .group_a_out(), .group_a_oe(),
    .group_b_out(single_b_out), .group_b_oe(single_b_oe), .capture_event(), .gate_arm_pulse(), .gate_armed(),
    .trigger_status(), .irq());
  ccs_pin_model u_pins (.sd_cmd(sd_cmd), .cap_cmd(cap_cmd), .group_a_out(group_a_out),
    .group_a_oe(group_a_oe), .shutdown_pin(shutdown_pin), .capture_pin(capture_pin), .pad_a(pad_a));
  // ------
  // Clock, capture counter, watchdog
  // ------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (capture_event === 1'b1) cap_cnt <= cap_cnt + 1;
  initial begin
    #300_000;
    error_cnt++;
    wrap_up();
  end
  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, exp, reg_rdata);
  endtask
  task automatic cap_pulse;
    @(posedge clk);
    cap_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    cap_cmd <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Cycles from a raw rise to the group A rise
  task automatic dt_delay(input logic [5:0] dt, output int cnt);
    wr(`CCS_OFF_CON3, {26'h0, dt});
    pwm_raw <= 1'b0;
    repeat (80) @(posedge clk);
    pwm_raw <= 1'b1;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (group_a_out[0] !== 1'b1 && cnt < 120);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    {rst, reg_wr, reg_rd, hw_trigger, single_edge_event, fifo_overflow, fifo_not_empty, pwm_raw} = 8'h80;
    {sd_cmd, cap_cmd, reg_addr, reg_wdata, bsy, capture_gate_mode} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`CCS_OFF_CON3, 32'h0, "control reset");
    rd(`CCS_OFF_IRQ_MASK, 32'h0, "mask reset");
    foreach (rows[i]) begin
      @(posedge clk);
      bsy            <= rows[i].busy;
      fifo_not_empty <= rows[i].ne;
      rd(`CCS_OFF_STAT, rows[i].exp, "status live bits");
    end
    @(posedge clk);
    {bsy, fifo_not_empty} <= '0;
    wr(`CCS_OFF_CON3, 32'hffff_ffff);
    rd(`CCS_OFF_CON3, 32'hc00f_003f, "control readback");
    wr(4'h2, 32'h0);
    rd(4'h2, 32'h0, "unmapped read");
    rd(`CCS_OFF_CON3, 32'hc00f_003f, "control after stray write");
    foreach (sd_con[i]) begin
      wr(`CCS_OFF_CON3, sd_con[i]);
      sd_cmd <= 1'b1;
      repeat (8) @(negedge clk);
      chk("a oe", {3{sd_con[i][19]}}, group_a_oe);
      if (sd_con[i][19]) chk("a pad", {3{sd_con[i][18]}}, pad_a);
      chk("b oe", {3{sd_con[i][17]}}, group_b_oe);
      if (sd_con[i][17]) chk("b out", {3{sd_con[i][16]}}, group_b_out);
      chk("single b oe", 3'h0, single_b_oe);
      rd(`CCS_OFF_STAT, 32'h10, "status in shutdown");
      @(posedge clk);
      sd_cmd <= 1'b0;
      repeat (4) @(posedge clk);
      wr(`CCS_OFF_STAT, 32'h0);
      rd(`CCS_OFF_STAT, 32'h0, "status after clear");
    end
    dt_delay(6'h00, d0);
    foreach (dts[i]) begin
      dt_delay(dts[i], dn);
      chk("dead time", d0 + dts[i], dn);
    end
    wr(`CCS_OFF_CON3, 32'h0);
    pwm_raw <= 1'b0;
    wr(`CCS_OFF_STAT, 32'h40);
    @(negedge clk);
    chk("trigger without enable", 1'b0, trigger_status);
    wr(`CCS_OFF_CON3, 32'hc000_0000);
    wr(`CCS_OFF_STAT, 32'h20);
    repeat (3) @(negedge clk);
    chk("held a oe", 3'h0, group_a_oe);
    wr(`CCS_OFF_STAT, 32'h40);
    @(negedge clk);
    chk("trigger set", 1'b1, trigger_status);
    rd(`CCS_OFF_STAT, 32'h80, "trigger status read");
    chk("released a oe", 3'h7, group_a_oe);
    wr(`CCS_OFF_STAT, 32'h20);
    @(negedge clk);
    chk("trigger cleared", 1'b0, trigger_status);
    @(posedge clk);
    hw_trigger <= 1'b1;
    @(posedge clk);
    hw_trigger <= 1'b0;
    @(negedge clk);
    chk("hardware trigger", 1'b1, trigger_status);
    wr(`CCS_OFF_STAT, 32'h20);
    rd(`CCS_OFF_IRQ_STAT, 32'h9, "irq status events");
    wr(`CCS_OFF_IRQ_MASK, 32'h2);
    @(posedge clk);
    single_edge_event <= 1'b1;
    @(posedge clk);
    single_edge_event <= 1'b0;
    @(negedge clk);
    chk("irq unmasked", 1'b1, irq);
    @(posedge clk);
    fifo_overflow <= 1'b1;
    @(posedge clk);
    fifo_overflow <= 1'b0;
    rd(`CCS_OFF_IRQ_STAT, 32'h6, "irq status flags");
    chk("irq after read", 1'b0, irq);
    rd(`CCS_OFF_STAT, 32'h0a, "sticky flags");
    wr(`CCS_OFF_STAT, 32'h0);
    rd(`CCS_OFF_STAT, 32'h0, "flags cleared");
    n = cap_cnt;
    cap_pulse();
    chk("capture on", n + 1, cap_cnt);
    wr(`CCS_OFF_STAT, 32'h4);
    cap_pulse();
    chk("capture off", n + 1, cap_cnt);
    wr(`CCS_OFF_STAT, 32'h0);
    for (int m = 0; m < 4; m++) begin
      capture_gate_mode <= m[1:0];
      wr(`CCS_OFF_STAT, 32'h400);
      @(negedge clk);
      chk("gate armed", (m == 1 || m == 2), gate_armed);
      rd(`CCS_OFF_STAT, 32'h0, "arm reads zero");
      cap_pulse();
      chk("gate disarmed", 1'b0, gate_armed);
    end
    wr(`CCS_OFF_CON3, 32'h0000_003f);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`CCS_OFF_CON3, 32'h0, "control after reset");
    wrap_up();
  end
endmodule
